// ### logic/ric_pkg.sv
/*
 * Package for the channel-ten reference input configuration block: register
 * indices, field positions, reset values, frequency codes and route encodings.
 * Assumes a word-wide Wishbone slave that decodes byte address = 4 * index.
 */
package ric_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register map (word index, byte address is four times the index)
  localparam logic [5:0] RIC_IDX_CFG = 6'h29;
  localparam logic [5:0] RIC_IDX_MODE = 6'h2c;
  localparam logic [5:0] RIC_IDX_STATUS = 6'h2d;
  localparam logic [7:0] RIC_CFG_RESET = 8'h03;
  localparam logic [7:0] RIC_MODE_RESET = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions of the configuration and mode registers
  localparam int RIC_CFG_PROG_BIT = 7;
  localparam int RIC_CFG_FIXED_BIT = 6;
  localparam int RIC_CFG_PROF_HI = 5;
  localparam int RIC_CFG_PROF_LO = 4;
  localparam int RIC_CFG_FREQ_HI = 3;
  localparam int RIC_CFG_FREQ_LO = 0;
  localparam int RIC_MODE_FAMILY_BIT = 0;

  //////////////////////////////////////////////////////////////////////////////
  // Frequency codes and nominal rates in kHz
  localparam int RIC_KHZ_W = 18;
  localparam logic [3:0] RIC_FC_8K = 4'h0;
  localparam logic [3:0] RIC_FC_T1E1 = 4'h1;
  localparam logic [3:0] RIC_FC_6M48 = 4'h2;
  localparam logic [3:0] RIC_FC_19M44 = 4'h3;
  localparam logic [3:0] RIC_FC_25M92 = 4'h4;
  localparam logic [3:0] RIC_FC_38M88 = 4'h5;
  localparam logic [3:0] RIC_FC_51M84 = 4'h6;
  localparam logic [3:0] RIC_FC_77M76 = 4'h7;
  localparam logic [3:0] RIC_FC_155M52 = 4'h8;
  localparam logic [3:0] RIC_FC_2K = 4'h9;
  localparam logic [3:0] RIC_FC_4K = 4'ha;
  localparam logic [RIC_KHZ_W-1:0] RIC_KHZ_8K = 18'd8;
  localparam logic [RIC_KHZ_W-1:0] RIC_KHZ_1544 = 18'd1544;
  localparam logic [RIC_KHZ_W-1:0] RIC_KHZ_2048 = 18'd2048;
  localparam logic [RIC_KHZ_W-1:0] RIC_KHZ_6480 = 18'd6480;
  localparam logic [RIC_KHZ_W-1:0] RIC_KHZ_19440 = 18'd19440;
  localparam logic [RIC_KHZ_W-1:0] RIC_KHZ_25920 = 18'd25920;
  localparam logic [RIC_KHZ_W-1:0] RIC_KHZ_38880 = 18'd38880;
  localparam logic [RIC_KHZ_W-1:0] RIC_KHZ_51840 = 18'd51840;
  localparam logic [RIC_KHZ_W-1:0] RIC_KHZ_77760 = 18'd77760;
  localparam logic [RIC_KHZ_W-1:0] RIC_KHZ_155520 = 18'd155520;
  localparam logic [RIC_KHZ_W-1:0] RIC_KHZ_2K = 18'd2;
  localparam logic [RIC_KHZ_W-1:0] RIC_KHZ_4K = 18'd4;
  localparam logic [RIC_KHZ_W-1:0] RIC_KHZ_NONE = 18'd0;
  // Fixed divider target rate is 8 kHz, so ratio = kHz >> 3
  localparam int RIC_TARGET_SHIFT = 3;
  localparam int RIC_RATIO_W = RIC_KHZ_W - RIC_TARGET_SHIFT;

  //////////////////////////////////////////////////////////////////////////////
  // Routing of the loop input
  typedef enum logic [1:0] {
    RIC_ROUTE_DIRECT,
    RIC_ROUTE_PROG,
    RIC_ROUTE_FIXED
  } ric_route_e;

  // Nominal rate of a code; zero marks a code with no meaning
  function automatic logic [RIC_KHZ_W-1:0] ric_freq_khz(input logic [3:0] code,
                                                        input logic family);
    unique case (code)
      RIC_FC_8K: ric_freq_khz = RIC_KHZ_8K;
      RIC_FC_T1E1: ric_freq_khz = family ? RIC_KHZ_2048 : RIC_KHZ_1544;
      RIC_FC_6M48: ric_freq_khz = RIC_KHZ_6480;
      RIC_FC_19M44: ric_freq_khz = RIC_KHZ_19440;
      RIC_FC_25M92: ric_freq_khz = RIC_KHZ_25920;
      RIC_FC_38M88: ric_freq_khz = RIC_KHZ_38880;
      RIC_FC_51M84: ric_freq_khz = RIC_KHZ_51840;
      RIC_FC_77M76: ric_freq_khz = RIC_KHZ_77760;
      RIC_FC_155M52: ric_freq_khz = RIC_KHZ_155520;
      RIC_FC_2K: ric_freq_khz = RIC_KHZ_2K;
      RIC_FC_4K: ric_freq_khz = RIC_KHZ_4K;
      default: ric_freq_khz = RIC_KHZ_NONE;
    endcase
  endfunction : ric_freq_khz

endpackage : ric_pkg

// ### logic/ric_fixed_div.sv
/*
 * Fixed pre-divider: emits one pulse for every ratio_i input edges, so that the
 * loop sees events at 8 kHz. Assumes edge_i is a one-cycle pulse on clk_i.
 */
module ric_fixed_div #(
  parameter int RATIO_W = 15
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Input events and ratio
  input wire logic edge_i,
  input wire logic [RATIO_W-1:0] ratio_i,
  // Divided events
  output logic pulse_o
);

  logic [RATIO_W-1:0] cnt_q;
  logic [RATIO_W-1:0] cnt_d;
  logic pulse_q;
  logic pulse_d;

  if (RATIO_W < 2) begin : g_chk
    $error("ric_fixed_div: RATIO_W too small");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter; >= keeps the count sane when the ratio shrinks mid-period
  always_comb begin
    cnt_d = cnt_q;
    pulse_d = 1'b0;
    if (edge_i) begin
      if (ratio_i <= RATIO_W'(1) || cnt_q >= ratio_i - RATIO_W'(1)) begin
        cnt_d = '0;
        pulse_d = 1'b1;
      end else begin
        cnt_d = cnt_q + RATIO_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      pulse_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse_o = pulse_q;

  //////////////////////////////////////////////////////////////////////////////
  property p_fix_wrap;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && edge_i && ratio_i > RATIO_W'(1) && cnt_q == ratio_i - RATIO_W'(1)
      |=> pulse_o && cnt_q == '0;
  endproperty
  a_fix_wrap: assert property (p_fix_wrap) else $error("fixed divider missed wrap");

  property p_fix_cause;
    @(posedge clk_i) disable iff (rst_i)
    $rose(pulse_o) |-> $past(edge_i);
  endproperty
  a_fix_cause: assert property (p_fix_cause) else $error("divider pulse without edge");

endmodule : ric_fixed_div

// ### logic/ric_channel_cfg.sv
/*
 * Channel-ten reference configuration: Wishbone register bank that steers the
 * channel to the loop and the frequency monitor, selects the activity profile
 * and decodes the nominal frequency. Assumes chan_i is asynchronous and
 * prog_div_i comes from the programmable pre-divider on clk_i.
 */
// Contract
// - Prog route bit sends channel through programmable divider
// - Fixed route bit sends channel to the loop through fixed divider; monitor stays direct
// - Fixed divider brings channel down to 8 kHz
// - Prog route overrides fixed route bit
// - Channel has own activity accumulator, four profiles
// - Profile field picks activity profile 0 to 3
// - Frequency code decodes to nominal reference rate
// - Code 0001 rate follows rate family bit
module ric_channel_cfg #(
  parameter int ADR_W = 8
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Channel inputs
  input wire logic chan_i,
  input wire logic prog_div_i,
  // Loop and monitor feeds
  output logic pll_ref_o,
  output logic mon_ref_o,
  output logic prog_div_en_o,
  output logic [1:0] route_o,
  // Activity monitor and frequency
  output logic [1:0] activity_profile_sel_o,
  output logic [ric_pkg::RIC_KHZ_W-1:0] freq_khz_o,
  output logic freq_valid_o
);

  if (ADR_W < 8) begin : g_chk
    $error("ric_channel_cfg: ADR_W must cover the register map");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave and registers
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [5:0] idx;
  logic wr_en;
  logic [7:0] status;

  assign idx = wb_adr_i[7:2];
  // Commit happens on the edge that raises ack, so a write lands exactly once
  assign wr_en = wb_cyc_i && wb_stb_i && !ack_q && wb_we_i && wb_sel_i[0];

  always_comb begin
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    cfg_d = cfg_q;
    mode_d = mode_q;
    rdat_d = '0;
    if (wr_en && idx == ric_pkg::RIC_IDX_CFG) begin
      cfg_d = wb_dat_i[7:0];
    end
    if (wr_en && idx == ric_pkg::RIC_IDX_MODE) begin
      mode_d = wb_dat_i[7:0] & 8'h01;
    end
    if (ack_d && !wb_we_i) begin
      unique case (idx)
        ric_pkg::RIC_IDX_CFG: rdat_d = {24'h000000, cfg_q};
        ric_pkg::RIC_IDX_MODE: rdat_d = {24'h000000, mode_q};
        ric_pkg::RIC_IDX_STATUS: rdat_d = {24'h000000, status};
        default: rdat_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
      cfg_q <= ric_pkg::RIC_CFG_RESET;
      mode_q <= ric_pkg::RIC_MODE_RESET;
    end else if (ce_i) begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      cfg_q <= cfg_d;
      mode_q <= mode_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  //////////////////////////////////////////////////////////////////////////////
  // Channel sampling; chan_i is asynchronous, so two flops before edge detect
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic chan_edge;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce_i) begin
      sync1_q <= chan_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Limitation: only inputs well below half of clk_i are resolved here
  assign chan_edge = sync2_q && !prev_q;

  //////////////////////////////////////////////////////////////////////////////
  // Decoded configuration
  logic prog_sel;
  logic fixed_sel;
  logic [3:0] fcode;
  logic family;
  logic [ric_pkg::RIC_KHZ_W-1:0] khz;
  logic [ric_pkg::RIC_RATIO_W-1:0] ratio;
  logic fix_pulse;

  assign prog_sel = cfg_q[ric_pkg::RIC_CFG_PROG_BIT];
  assign fixed_sel = cfg_q[ric_pkg::RIC_CFG_FIXED_BIT];
  assign fcode = cfg_q[ric_pkg::RIC_CFG_FREQ_HI:ric_pkg::RIC_CFG_FREQ_LO];
  assign family = mode_q[ric_pkg::RIC_MODE_FAMILY_BIT];
  assign khz = ric_pkg::ric_freq_khz(fcode, family);
  assign ratio = khz[ric_pkg::RIC_KHZ_W-1:ric_pkg::RIC_TARGET_SHIFT];

  ric_fixed_div #(
    .RATIO_W(ric_pkg::RIC_RATIO_W)
  ) u_fixed_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .edge_i(chan_edge),
    .ratio_i(ratio),
    .pulse_o(fix_pulse)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Routing and monitor outputs, all registered
  ric_pkg::ric_route_e route_q;
  ric_pkg::ric_route_e route_d;
  logic pll_q;
  logic pll_d;
  logic mon_q;
  logic mon_d;
  logic pen_q;
  logic [1:0] prof_q;
  logic [ric_pkg::RIC_KHZ_W-1:0] khz_q;
  logic fvalid_q;
  logic warn_q;
  logic warn_d;

  always_comb begin
    if (prog_sel) begin
      route_d = ric_pkg::RIC_ROUTE_PROG;
    end else if (fixed_sel) begin
      route_d = ric_pkg::RIC_ROUTE_FIXED;
    end else begin
      route_d = ric_pkg::RIC_ROUTE_DIRECT;
    end
    unique case (route_d)
      ric_pkg::RIC_ROUTE_PROG: pll_d = prog_div_i;
      ric_pkg::RIC_ROUTE_FIXED: pll_d = fix_pulse;
      default: pll_d = chan_edge;
    endcase
    mon_d = prog_sel ? prog_div_i : chan_edge;
    // Flags a setup that software should avoid: prog route with non-8 kHz code
    warn_d = prog_sel && fcode != ric_pkg::RIC_FC_8K;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      route_q <= ric_pkg::RIC_ROUTE_DIRECT;
      pll_q <= 1'b0;
      mon_q <= 1'b0;
      pen_q <= 1'b0;
      prof_q <= 2'h0;
      khz_q <= '0;
      fvalid_q <= 1'b0;
      warn_q <= 1'b0;
    end else if (ce_i) begin
      route_q <= route_d;
      pll_q <= pll_d;
      mon_q <= mon_d;
      pen_q <= prog_sel;
      prof_q <= cfg_q[ric_pkg::RIC_CFG_PROF_HI:ric_pkg::RIC_CFG_PROF_LO];
      khz_q <= khz;
      fvalid_q <= khz != ric_pkg::RIC_KHZ_NONE;
      warn_q <= warn_d;
    end
  end

  assign status = {4'h0, warn_q, fvalid_q, 2'(route_q)};
  assign pll_ref_o = pll_q;
  assign mon_ref_o = mon_q;
  assign prog_div_en_o = pen_q;
  assign route_o = 2'(route_q);
  assign activity_profile_sel_o = prof_q;
  assign freq_khz_o = khz_q;
  assign freq_valid_o = fvalid_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_prog_pll;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && prog_sel |=> pll_ref_o == $past(prog_div_i) && mon_ref_o == $past(prog_div_i);
  endproperty
  a_prog_pll: assert property (p_prog_pll) else $error("prog route not followed");

  property p_direct_mon;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !prog_sel |=> mon_ref_o == $past(chan_edge);
  endproperty
  a_direct_mon: assert property (p_direct_mon) else $error("monitor not fed directly");

  property p_fixed_pll;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !prog_sel && fixed_sel |=> pll_ref_o == $past(fix_pulse) && route_o == 2'h2;
  endproperty
  a_fixed_pll: assert property (p_fixed_pll) else $error("fixed route not followed");

  property p_prog_wins;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && prog_sel && fixed_sel |=> route_o == 2'h1 && prog_div_en_o;
  endproperty
  a_prog_wins: assert property (p_prog_wins) else $error("fixed bit not ignored");

  property p_profile;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> activity_profile_sel_o == $past(cfg_q[5:4]);
  endproperty
  a_profile: assert property (p_profile) else $error("profile select mismatch");

  property p_freq_19m;
    @(posedge clk_i) disable iff (rst_i)
    // Sampled reset keeps the release edge out: khz_q still holds its reset value there
    !rst_i && ce_i && fcode == 4'h3 |=> freq_khz_o == 18'd19440 && freq_valid_o;
  endproperty
  a_freq_19m: assert property (p_freq_19m) else $error("code 0011 not 19.44 MHz");

  property p_freq_unused;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && fcode == 4'hf |=> !freq_valid_o && freq_khz_o == '0;
  endproperty
  a_freq_unused: assert property (p_freq_unused) else $error("unused code marked valid");

  property p_family;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && fcode == 4'h1 |=> freq_khz_o == ($past(family) ? 18'd2048 : 18'd1544);
  endproperty
  a_family: assert property (p_family) else $error("code 0001 ignores family");

  property p_write_cfg;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && wr_en && idx == 6'h29 |=> cfg_q == $past(wb_dat_i[7:0]) ##1 !ce_i ||
      activity_profile_sel_o == cfg_q[5:4];
  endproperty
  a_write_cfg: assert property (p_write_cfg) else $error("write did not take effect");

endmodule : ric_channel_cfg

// ### verif/test_ric_channel_cfg.sv
/*
 * Self-checking bench for the channel-ten reference configuration block.
 * Assumes the block answers classic Wishbone cycles and that ce_i may stay high.
 */
module test_ric_channel_cfg;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] A_CFG = 8'ha4;
  localparam logic [7:0] A_MODE = 8'hb0;
  localparam logic [7:0] A_ST = 8'hb4;
  localparam logic [7:0] A_NONE = 8'h10;
  localparam logic [17:0] KHZ [16] = '{18'h8, 18'h608, 18'h1950, 18'h4bf0, 18'h6540,
    18'h97e0, 18'hca80, 18'h12fc0, 18'h25f80, 18'h2, 18'h4, 18'h0, 18'h0, 18'h0, 18'h0, 18'h0};

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic chan_i = 1'b0;
  logic prog_div_i = 1'b0;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic pll_ref_o;
  logic mon_ref_o;
  logic prog_div_en_o;
  logic [1:0] route_o;
  logic [1:0] activity_profile_sel_o;
  logic [17:0] freq_khz_o;
  logic freq_valid_o;
  int fails = 0;
  int check_count = 0;
  int pll_cnt = 0;
  int mon_cnt = 0;

  ric_channel_cfg ric_channel_cfg_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .chan_i(chan_i), .prog_div_i(prog_div_i), .pll_ref_o(pll_ref_o), .mon_ref_o(mon_ref_o),
    .prog_div_en_o(prog_div_en_o), .route_o(route_o),
    .activity_profile_sel_o(activity_profile_sel_o), .freq_khz_o(freq_khz_o),
    .freq_valid_o(freq_valid_o)
  );

  always #5 clk_i = ~clk_i;

  // Running pulse counts; scenarios compare differences, so no reset is needed
  always @(posedge clk_i) begin
    if (pll_ref_o === 1'b1) pll_cnt <= pll_cnt + 1;
    if (mon_ref_o === 1'b1) mon_cnt <= mon_cnt + 1;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Holds the request until ack is sampled high at a rising edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      $display("MISMATCH wb_ack expected 1 seen timeout");
      summarize();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [31:0] d;
    wb(1'b1, adr, {24'h0, dat}, 4'h1, d);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] adr, input logic [7:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, 4'hf, d);
    chk(what, d, {24'h0, exp});
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask : settle

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : do_reset

  task automatic chan_edges(input int n);
    repeat (n) begin
      @(posedge clk_i);
      chan_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chan_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
  endtask : chan_edges

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    settle();
    rd("cfg reset", A_CFG, 8'h03);
    chk("freq reset", freq_khz_o, KHZ[3]);
    chk("valid reset", freq_valid_o, 1'b1);
    chk("route reset", route_o, 2'h0);
    chk("profile reset", activity_profile_sel_o, 2'h0);
    rd("unmapped", A_NONE, 8'h00);
    wr(A_NONE, 8'hff);
    rd("cfg after unmapped", A_CFG, 8'h03);
    $display("test reset done");
  endtask : t_reset

  task automatic t_codes();
    logic [31:0] d;
    for (int c = 0; c < 16; c++) begin
      wr(A_CFG, {4'h0, c[3:0]});
      settle();
      chk("freq code", freq_khz_o, KHZ[c]);
      chk("freq valid", freq_valid_o, c < 11);
      rd("cfg code", A_CFG, {4'h0, c[3:0]});
    end
    wr(A_MODE, 8'hff);
    rd("mode", A_MODE, 8'h01);
    wr(A_CFG, 8'h01);
    settle();
    chk("freq family 1", freq_khz_o, 18'h800);
    wr(A_MODE, 8'h00);
    settle();
    chk("freq family 0", freq_khz_o, 18'h608);
    $display("test codes done");
  endtask : t_codes

  task automatic t_profiles();
    logic [31:0] d;
    for (int p = 0; p < 4; p++) begin
      wr(A_CFG, {2'h0, p[1:0], 4'h3});
      settle();
      chk("profile", activity_profile_sel_o, p[1:0]);
    end
    wb(1'b1, A_CFG, 32'h0, 4'he, d);
    rd("cfg sel0 low", A_CFG, 8'h33);
    $display("test profiles done");
  endtask : t_profiles

  task automatic t_routes();
    int p0;
    int m0;
    wr(A_CFG, 8'h03);
    settle();
    p0 = pll_cnt;
    m0 = mon_cnt;
    chan_edges(5);
    chk("direct pll", pll_cnt - p0, 5);
    chk("direct mon", mon_cnt - m0, 5);
    wr(A_CFG, 8'hc0);
    settle();
    chk("prog route", route_o, 2'h1);
    chk("prog enable", prog_div_en_o, 1'b1);
    rd("status prog", A_ST, 8'h05);
    p0 = pll_cnt;
    m0 = mon_cnt;
    repeat (3) begin
      @(posedge clk_i);
      prog_div_i <= 1'b1;
      @(posedge clk_i);
      prog_div_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    chan_edges(2);
    chk("prog pll", pll_cnt - p0, 3);
    chk("prog mon", mon_cnt - m0, 3);
    wr(A_CFG, 8'h83);
    rd("status warn", A_ST, 8'h0d);
    wr(A_CFG, 8'h40);
    settle();
    chk("fixed route", route_o, 2'h2);
    chk("fixed enable", prog_div_en_o, 1'b0);
    p0 = pll_cnt;
    m0 = mon_cnt;
    chan_edges(4);
    chk("fixed 8k pll", pll_cnt - p0, 4);
    chk("fixed mon", mon_cnt - m0, 4);
    $display("test routes done");
  endtask : t_routes

  // Low enable must freeze the sampler, so edges seen meanwhile are lost
  task automatic t_enable();
    int p0;
    wr(A_CFG, 8'h03);
    settle();
    p0 = pll_cnt;
    ce_i <= 1'b0;
    chan_edges(3);
    chk("frozen pll", pll_cnt - p0, 0);
    ce_i <= 1'b1;
    chan_edges(2);
    chk("resumed pll", pll_cnt - p0, 2);
    $display("test enable done");
  endtask : t_enable

  // A 6.48 MHz source needs 810 input edges per 8 kHz event
  task automatic t_fixed_div();
    int p0;
    int m0;
    do_reset();
    wr(A_CFG, 8'h42);
    settle();
    rd("status fixed", A_ST, 8'h06);
    wr(A_ST, 8'hff);
    rd("status read only", A_ST, 8'h06);
    p0 = pll_cnt;
    m0 = mon_cnt;
    chan_edges(809);
    chk("div early", pll_cnt - p0, 0);
    chan_edges(1);
    chk("div event", pll_cnt - p0, 1);
    chk("div mon", mon_cnt - m0, 810);
    $display("test fixed divider done");
  endtask : t_fixed_div

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_codes();
    t_profiles();
    t_routes();
    t_enable();
    t_fixed_div();
    summarize();
  end

endmodule : test_ric_channel_cfg
